// ---- bench/nvp_ser_prog.sv ----
// serial programmer model driving the download port
`timescale 1ns/1ps
module nvp_ser_prog (
  // serial pins
  output reg  sck,
  output reg  mosi,
  input  wire miso
);
  initial begin
    sck  = 1'h0;
    mosi = 1'h0;
  end
  // one whole four-byte instruction, msb first
  task xfer(input [31:0] cmd, output [31:0] rsp);
    integer i;
    begin
      for (i = 31; i >= 0; i = i - 1) begin
        mosi <= cmd[i];
        #62.5 sck <= 1'h1;
        rsp[i] = miso;
        #62.5 sck <= 1'h0;
      end
    end
  endtask
endmodule // nvp_ser_prog

// ---- bench/nvp_top_properties.sv ----
// port assertions for the programming front end
`timescale 1ns/1ps
module nvp_top_props (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // register bus
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  // pins
  input wire        pp_oe_n,
  input wire        pp_data_oe,
  input wire        ready_not_pending,
  input wire        ser_reset_n,
  input wire        miso_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bus_release:
    assert property (pp_oe_n [*4] |-> !pp_data_oe) else $error("bus driven without enable");
  a_bus_cause:
    assert property ($rose(pp_data_oe) |-> !$past(pp_oe_n, 2)) else $error("bus driven early");
  a_session_end:
    assert property (ser_reset_n [*4] |-> !miso_oe) else $error("serial out after reset high");
  a_busy_min:
    assert property ($fell(ready_not_pending) |=> !ready_not_pending [*8])
      else $error("busy too short");
  a_write_answer:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("no write response");
  a_read_answer:
    assert property (arvalid && arready |=> rvalid) else $error("no read data");
  a_resp_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
  a_data_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
  a_write_block:
    assert property (bvalid |-> !awready && !wready) else $error("write taken during response");
  a_read_block:
    assert property (rvalid |-> !arready) else $error("read taken during data");
endmodule // nvp_top_props

bind nvp_top nvp_top_props u_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .pp_oe_n,
  .pp_data_oe, .ready_not_pending, .ser_reset_n, .miso_oe);

// ---- bench/tb_top.sv ----
// self-checking bench for the programming front end
`timescale 1ns/1ps
`include "nvp_regs.vh"
module tb_top;
  localparam [23:0] SIGS = 24'h3C2D1E; // arbitrary value
  reg         aclk = 1'h0, aresetn = 1'h0;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00, pp_data_in = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg  [3:0]  wstrb = 4'hF;
  reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg         load_kind_bit1 = 1'h0, load_kind_bit0 = 1'h0;
  reg         byte_sel_one = 1'h0, byte_sel_two = 1'h0, programming_clock_pin = 1'h0;
  reg         pp_wr_n = 1'h1, pp_oe_n = 1'h1, ser_reset_n = 1'h1;
  wire        awready, wready, bvalid, arready, rvalid, pp_data_oe, ready_not_pending;
  wire        sck, mosi, miso, miso_oe;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [7:0]  pp_data_out;
  integer     mismatches = 0, num_checks = 0;
  reg  [31:0] r;
  reg  [1:0]  resp;

  nvp_top #(.WAIT_SHORT(21'h64), .WAIT_LONG(21'hC8), .SIG0(SIGS[7:0]), .SIG1(SIGS[15:8]),
    .SIG2(SIGS[23:16])) dut (.*);
  nvp_ser_prog prog (.sck(sck), .mosi(mosi), .miso(miso));
  always #4 aclk = ~aclk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task tmo(input integer n);
    if (n >= 1000) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: wait ran out", $time);
      conclude;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task axi_wr(input [7:0] a, input [31:0] d, output [1:0] rs);
    integer n;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      n = 0;
      rs = 2'h3;
      while (rs === 2'h3) begin
        @(posedge aclk);
        n = n + 1;
        tmo(n);
        if (awready) awvalid <= 1'h0;
        if (wready) wvalid <= 1'h0;
        if (bvalid && bready) begin
          rs = bresp;
          bready <= 1'h0;
        end else if (n > 3) bready <= 1'h1;
      end
    end
  endtask
  task axi_rd(input [7:0] a, input [31:0] e, input [1:0] er);
    integer n;
    reg [1:0] rs;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      n = 0;
      rs = 2'h3;
      while (rs === 2'h3) begin
        @(posedge aclk);
        n = n + 1;
        tmo(n);
        if (arready) arvalid <= 1'h0;
        if (rvalid && rready) begin
          rs = rresp;
          chk(rdata, e);
          rready <= 1'h0;
        end else if (n > 3) rready <= 1'h1;
      end
      chk(rs, er);
    end
  endtask
  task pp_load(input [1:0] k, input [7:0] d);
    begin
      {load_kind_bit1, load_kind_bit0} <= k;
      {byte_sel_two, byte_sel_one} <= 2'h0;
      pp_data_in <= d;
      cyc(4);
      programming_clock_pin <= 1'h1;
      cyc(4);
      programming_clock_pin <= 1'h0;
      cyc(4);
    end
  endtask
  task pp_strobe;
    integer n;
    begin
      pp_wr_n <= 1'h0;
      cyc(4);
      pp_wr_n <= 1'h1;
      cyc(2);
      chk(ready_not_pending, 32'h0);
      n = 0;
      while (ready_not_pending !== 1'h1) begin
        cyc(1);
        n = n + 1;
        tmo(n);
      end
    end
  endtask
  task pp_read(input [1:0] s, input [7:0] e);
    begin
      {byte_sel_two, byte_sel_one} <= s;
      pp_oe_n <= 1'h0;
      cyc(6);
      chk(pp_data_oe, 32'h1);
      chk(pp_data_out, {24'h0, e});
      pp_oe_n <= 1'h1;
      cyc(6);
      chk(pp_data_oe, 32'h0);
    end
  endtask
  task spoll;
    integer n;
    begin
      n = 0;
      r = 32'h1;
      while (r[0] !== 1'h0) begin
        prog.xfer(32'hF0000000, r);
        n = n + 1;
        tmo(n * 25);
      end
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    begin
      axi_rd(`NVP_OFF_CAL, 32'h80, 2'h0);
      axi_rd(`NVP_OFF_FUSE, 32'hFFFFFF, 2'h0);
      axi_rd(8'h10, 32'h0, 2'h2);
      axi_wr(8'h10, 32'h1, resp);
      chk(resp, 32'h2);
      axi_wr(`NVP_OFF_CAL, 32'h5A, resp);
      axi_rd(`NVP_OFF_CAL, 32'h5A, 2'h0);
      $display("test registers done");
    end
  endtask
  task t_par;
    integer i;
    begin
      axi_wr(`NVP_OFF_CTRL, 32'h1, resp);
      pp_load(2'h2, 8'h40);
      pp_load(2'h1, 8'hA5);
      byte_sel_one <= 1'h1;
      cyc(4);
      pp_strobe;
      pp_load(2'h2, 8'h20);
      pp_load(2'h1, 8'hF0);
      pp_strobe;
      pp_load(2'h1, 8'hFF);
      pp_strobe;
      pp_load(2'h2, 8'h04);
      pp_read(2'h0, 8'hFF);
      pp_read(2'h3, 8'hA5);
      pp_read(2'h1, 8'hF0);
      axi_rd(`NVP_OFF_FUSE, 32'hF0A5FF, 2'h0);
      pp_load(2'h2, 8'h08);
      for (i = 0; i < 3; i = i + 1) begin
        pp_load(2'h0, i[7:0]);
        pp_read(2'h0, SIGS[8*i +: 8]);
      end
      pp_load(2'h0, 8'h00);
      pp_read(2'h1, 8'h5A);
      axi_wr(`NVP_OFF_CTRL, 32'h0, resp);
      $display("test parallel done");
    end
  endtask
  task t_ser;
    integer i;
    reg [7:0] d;
    begin
      ser_reset_n <= 1'h0;
      cyc(6);
      axi_rd(`NVP_OFF_STATUS, 32'h4, 2'h0);
      prog.xfer(32'hAC800000, r);
      axi_rd(`NVP_OFF_STATUS, 32'h4, 2'h0);
      prog.xfer(32'hAC530000, r);
      chk(r[15:8], 32'h53);
      axi_rd(`NVP_OFF_STATUS, 32'h5, 2'h0);
      prog.xfer(32'hAC800000, r);
      prog.xfer(32'hF0000000, r);
      chk(r[0], 32'h1);
      spoll;
      prog.xfer(32'hA0000500, r);
      chk(r[7:0], 32'hFF);
      for (i = 0; i < 2; i = i + 1) begin
        d = i ? 8'hC3 : 8'h3C;
        prog.xfer({24'hC00005, d}, r);
        spoll;
        prog.xfer(32'hA0000500, r);
        chk(r[7:0], {24'h0, d});
      end
      prog.xfer(32'h40004312, r);
      prog.xfer(32'h48004334, r);
      prog.xfer(32'h4C004000, r);
      spoll;
      prog.xfer(32'h20004300, r);
      chk(r[7:0], 32'h12);
      prog.xfer(32'h28004300, r);
      chk(r[7:0], 32'h34);
      prog.xfer(32'h20000300, r);
      chk(r[7:0], 32'hFF);
      @(posedge aclk);
      ser_reset_n <= 1'h1;
      cyc(6);
      chk(miso_oe, 32'h0);
      axi_rd(`NVP_OFF_STATUS, 32'h0, 2'h0);
      $display("test serial done");
    end
  endtask

  initial begin
    cyc(3);
    aresetn <= 1'h1;
    t_regs;
    t_par;
    t_ser;
    conclude;
  end
endmodule // tb_top

// ---- hdl/nvp_spi_shift.v ----
// serial byte shifter sampled by the cpu clock
`timescale 1ns/1ps
module nvp_spi_shift (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       clear,
  // serial pins
  input  wire       sck_pin,
  input  wire       mosi_pin,
  output reg        miso,
  // byte side
  input  wire       tx_load,
  input  wire [7:0] tx_byte,
  output reg  [7:0] rx_byte,
  output reg        rx_done
);
  reg       sck_s1;
  reg       sck_s2;
  reg       sck_s3;
  reg       mosi_s1;
  reg       mosi_s2;
  reg [2:0] cnt;
  reg [7:0] rx_sh;
  reg [7:0] tx_sh;
  wire      rise = sck_s2 & ~sck_s3;
  wire      fall = ~sck_s2 & sck_s3;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      sck_s1  <= 1'b0;
      sck_s2  <= 1'b0;
      sck_s3  <= 1'b0;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sck_s1  <= sck_pin;
      sck_s2  <= sck_s1;
      sck_s3  <= sck_s2;
      mosi_s1 <= mosi_pin;
      mosi_s2 <= mosi_s1;
    end
  end

  // ----------------------------------------
  // shifting
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt     <= 3'h0;
      rx_sh   <= 8'h00;
      tx_sh   <= 8'h00;
      rx_byte <= 8'h00;
      rx_done <= 1'b0;
      miso    <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (rise) begin
        rx_sh <= {rx_sh[6:0], mosi_s2};
        cnt   <= cnt + 3'h1;
        if (cnt == 3'h7) begin
          rx_byte <= {rx_sh[6:0], mosi_s2};
          rx_done <= 1'b1;
        end
      end
      if (tx_load) begin
        tx_sh <= tx_byte;
      end else if (fall) begin
        miso  <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end
endmodule // nvp_spi_shift

// ---- hdl/nvp_top.v ----
// nonvolatile programming front end: parallel and serial ports
`timescale 1ns/1ps
`include "nvp_regs.vh"
module nvp_top #(
  parameter [20:0] WAIT_SHORT = `NVP_T_WD_SHORT_US * `NVP_CLK_MHZ,
  parameter [20:0] WAIT_LONG  = `NVP_T_WD_LONG_US * `NVP_CLK_MHZ,
  parameter [7:0]  SIG0       = 8'h11, // arbitrary value
  parameter [7:0]  SIG1       = 8'h22, // arbitrary value
  parameter [7:0]  SIG2       = 8'h33  // arbitrary value
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite slave
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // parallel port
  input  wire [7:0]  pp_data_in,
  output reg  [7:0]  pp_data_out,
  output wire        pp_data_oe,
  input  wire        load_kind_bit1,
  input  wire        load_kind_bit0,
  input  wire        byte_sel_one,
  input  wire        byte_sel_two,
  input  wire        programming_clock_pin,
  input  wire        pp_wr_n,
  input  wire        pp_oe_n,
  output wire        ready_not_pending,
  // serial port
  input  wire        ser_reset_n,
  input  wire        sck,
  input  wire        mosi,
  output wire        miso,
  output wire        miso_oe
);
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_WALK = 3'b010;
  localparam [2:0] S_WAIT = 3'b100;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg  [15:0] p_s1;
  reg  [15:0] p_s2;
  reg  [2:0]  p_s3;
  wire [15:0] p_raw = {pp_data_in, load_kind_bit1, load_kind_bit0, byte_sel_one,
                       byte_sel_two, programming_clock_pin, pp_wr_n, pp_oe_n,
                       ser_reset_n};
  wire [7:0]  p_data  = p_s2[15:8];
  wire [1:0]  p_kind  = p_s2[7:6];
  wire        p_bs1   = p_s2[5];
  wire        p_bs2   = p_s2[4];
  wire        p_oe_n  = p_s2[1];
  wire        p_rst_n = p_s2[0];
  wire        pclk_up = p_s2[3] & ~p_s3[2];
  wire        wr_down = ~p_s2[2] & p_s3[1];

  always @(posedge aclk) begin
    if (!aresetn) begin
      p_s1 <= 16'h0007;
      p_s2 <= 16'h0007;
      p_s3 <= 3'h3;
    end else begin
      p_s1 <= p_raw;
      p_s2 <= p_s1;
      p_s3 <= {p_s2[3], p_s2[2], p_s2[0]};
    end
  end

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  reg  [2:0]  state;
  reg         op_erase;
  reg  [12:0] walk;
  reg  [20:0] wait_cnt;
  reg  [6:0]  page;
  reg         par_mode;
  reg         prog_en;
  reg  [7:0]  cal;
  reg  [7:0]  fuse_lo;
  reg  [7:0]  fuse_hi;
  reg  [7:0]  lock;
  reg  [7:0]  p_cmd;
  reg  [7:0]  p_dlo;
  reg  [7:0]  p_alo;
  reg  [7:0]  b1;
  reg  [7:0]  b2;
  reg  [7:0]  b3;
  reg  [1:0]  idx;
  reg         tx_load;
  reg  [7:0]  tx_byte;
  reg  [15:0] flash [0:8191];
  reg  [7:0]  eeprom [0:511];
  reg  [7:0]  pbuf_lo [0:63];
  reg  [7:0]  pbuf_hi [0:63];
  reg  [7:0]  spi_rd;
  wire        busy = ~state[0];
  wire        ser_active = ~p_rst_n & ~par_mode;
  wire [7:0]  rx_byte;
  wire        rx_done;
  wire [12:0] faddr = {b2[4:0], rx_byte};
  wire [8:0]  eaddr = {b2[0], rx_byte};

  assign ready_not_pending = ~busy;
  assign pp_data_oe        = par_mode & ~p_oe_n;
  assign miso_oe           = ser_active;

  nvp_spi_shift u_shift (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (~ser_active),
    .sck_pin  (sck),
    .mosi_pin (mosi),
    .miso     (miso),
    .tx_load  (tx_load),
    .tx_byte  (tx_byte),
    .rx_byte  (rx_byte),
    .rx_done  (rx_done)
  );

  // ----------------------------------------
  // serial read data for the fourth byte
  // ----------------------------------------
  always @* begin
    spi_rd = 8'h00;
    if (prog_en) begin
      case (b1)
        `NVP_SI_POLL:  spi_rd = {7'h00, busy};
        `NVP_SI_RDL:   spi_rd = busy ? 8'hFF : flash[faddr][7:0];
        `NVP_SI_RDH:   spi_rd = busy ? 8'hFF : flash[faddr][15:8];
        `NVP_SI_RDEE:  spi_rd = busy ? 8'hFF : eeprom[eaddr];
        `NVP_SI_RDLK:  spi_rd = (b2 == `NVP_SI_HI) ? fuse_hi : lock;
        `NVP_SI_RDFUS: spi_rd = (b2 == `NVP_SI_HI) ? 8'hFF : fuse_lo;
        `NVP_SI_RDCAL: spi_rd = cal;
        `NVP_SI_RDSIG: begin
          case (rx_byte[1:0])
            2'h0:    spi_rd = SIG0;
            2'h1:    spi_rd = SIG1;
            2'h2:    spi_rd = SIG2;
            default: spi_rd = 8'hFF;
          endcase
        end
        default:       spi_rd = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // parallel read data
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      pp_data_out <= 8'h00;
    end else if (p_cmd == `NVP_PC_FL_RD) begin
      case ({p_bs2, p_bs1})
        2'b00:   pp_data_out <= fuse_lo;
        2'b11:   pp_data_out <= fuse_hi;
        2'b01:   pp_data_out <= lock;
        default: pp_data_out <= 8'hFF;
      endcase
    end else if (p_cmd == `NVP_PC_SIG_RD) begin
      if (p_bs1) begin
        pp_data_out <= (p_alo == 8'h00) ? cal : 8'hFF;
      end else begin
        case (p_alo)
          8'h00:   pp_data_out <= SIG0;
          8'h01:   pp_data_out <= SIG1;
          8'h02:   pp_data_out <= SIG2;
          default: pp_data_out <= 8'hFF;
        endcase
      end
    end else begin
      pp_data_out <= 8'hFF;
    end
  end

  // ----------------------------------------
  // programming engine
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state    <= S_IDLE;
      op_erase <= 1'b0;
      walk     <= 13'h0000;
      wait_cnt <= 21'h000000;
      page     <= 7'h00;
      prog_en  <= 1'b0;
      fuse_lo  <= `NVP_FUSE_LO_RST;
      fuse_hi  <= `NVP_FUSE_HI_RST;
      lock     <= `NVP_LOCK_RST;
      p_cmd    <= 8'h00;
      p_dlo    <= 8'hFF;
      p_alo    <= 8'h00;
      b1       <= 8'h00;
      b2       <= 8'h00;
      b3       <= 8'h00;
      idx      <= 2'h0;
      tx_load  <= 1'b0;
      tx_byte  <= 8'h00;
    end else begin
      tx_load <= 1'b0;
      if (!ser_active) begin
        prog_en <= 1'b0;
        idx     <= 2'h0;
      end
      // parallel loads on the programming clock
      if (par_mode && pclk_up) begin
        case (p_kind)
          `NVP_LK_CMD:  p_cmd <= p_data;
          `NVP_LK_DATA: if (!p_bs1) p_dlo <= p_data;
          `NVP_LK_ADDR: if (!p_bs1) p_alo <= p_data;
          default:      p_cmd <= p_cmd;
        endcase
      end
      // parallel write strobe
      if (par_mode && wr_down && !busy) begin
        if (p_cmd == `NVP_PC_FUSE_WR && !p_bs2) begin
          if (p_bs1) begin
            fuse_hi <= p_dlo;
          end else begin
            fuse_lo <= p_dlo;
          end
          state    <= S_WAIT;
          wait_cnt <= WAIT_SHORT;
        end else if (p_cmd == `NVP_PC_LOCK_WR) begin
          lock     <= lock & p_dlo;
          state    <= S_WAIT;
          wait_cnt <= WAIT_SHORT;
        end else if (p_cmd == `NVP_PC_ERASE) begin
          state    <= S_WALK;
          op_erase <= 1'b1;
          walk     <= 13'h0000;
          wait_cnt <= WAIT_LONG;
        end
      end
      // serial bytes
      if (ser_active && rx_done) begin
        idx     <= idx + 2'h1;
        tx_load <= 1'b1;
        tx_byte <= (idx == 2'h2) ? spi_rd : rx_byte;
        if (idx == 2'h0) b1 <= rx_byte;
        if (idx == 2'h1) b2 <= rx_byte;
        if (idx == 2'h2) b3 <= rx_byte;
      end
      if (ser_active && rx_done && idx == 2'h3) begin
        if (b1 == `NVP_SI_PRE && b2 == `NVP_SI_EN) begin
          prog_en <= 1'b1;
        end else if (prog_en && !busy) begin
          case (b1)
            `NVP_SI_PRE: begin
              if (b2 == `NVP_SI_ERASE) begin
                state    <= S_WALK;
                op_erase <= 1'b1;
                walk     <= 13'h0000;
                wait_cnt <= WAIT_LONG;
              end else if (b2 == `NVP_SI_WRLK) begin
                lock     <= lock & rx_byte;
                state    <= S_WAIT;
                wait_cnt <= WAIT_SHORT;
              end else if (b2 == `NVP_SI_WRFUS) begin
                fuse_lo  <= rx_byte;
                state    <= S_WAIT;
                wait_cnt <= WAIT_SHORT;
              end else if (b2 == `NVP_SI_WRFUSH) begin
                fuse_hi  <= rx_byte;
                state    <= S_WAIT;
                wait_cnt <= WAIT_SHORT;
              end
            end
            `NVP_SI_LDL: pbuf_lo[b3[5:0]] <= rx_byte;
            `NVP_SI_LDH: pbuf_hi[b3[5:0]] <= rx_byte;
            `NVP_SI_WRPG: begin
              page     <= {b2[4:0], b3[7:6]};
              state    <= S_WALK;
              op_erase <= 1'b0;
              walk     <= 13'h0000;
              wait_cnt <= WAIT_SHORT;
            end
            `NVP_SI_WREE: begin
              eeprom[{b2[0], b3}] <= rx_byte;
              state    <= S_WAIT;
              wait_cnt <= WAIT_LONG;
            end
            default: state <= state;
          endcase
        end
      end
      // busy sequencing
      case (state)
        S_IDLE: walk <= walk;
        S_WALK: begin
          if (wait_cnt != 21'h000000) wait_cnt <= wait_cnt - 21'h000001;
          walk <= walk + 13'h0001;
          if (op_erase) begin
            flash[walk] <= 16'hFFFF;
            if (walk <= `NVP_EE_LAST) eeprom[walk[8:0]] <= 8'hFF;
            if (walk == `NVP_FLASH_LAST) begin
              lock  <= `NVP_LOCK_RST;
              state <= S_WAIT;
            end
          end else begin
            flash[{page, walk[5:0]}] <= {pbuf_hi[walk[5:0]], pbuf_lo[walk[5:0]]};
            if (walk == `NVP_PAGE_LAST) state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (wait_cnt == 21'h000000) begin
            state <= S_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 21'h000001;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  reg         aw_hold;
  reg         w_hold;
  reg  [7:0]  aw_q;
  reg  [7:0]  w_q;
  reg         w_en;

  assign awready = ~aw_hold & ~bvalid;
  assign wready  = ~w_hold & ~bvalid;
  assign arready = ~rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold  <= 1'b0;
      w_hold   <= 1'b0;
      aw_q     <= 8'h00;
      w_q      <= 8'h00;
      w_en     <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= `NVP_RESP_OKAY;
      par_mode <= 1'b0;
      cal      <= `NVP_CAL_RST;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        aw_q    <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        w_q    <= wdata[7:0];
        w_en   <= wstrb[0];
      end
      if (aw_hold && w_hold && !bvalid) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= `NVP_RESP_OKAY;
        if (aw_q == `NVP_OFF_CTRL) begin
          if (w_en) par_mode <= w_q[`NVP_CTRL_PAR];
        end else if (aw_q == `NVP_OFF_CAL) begin
          if (w_en) cal <= w_q;
        end else if (aw_q != `NVP_OFF_STATUS && aw_q != `NVP_OFF_FUSE) begin
          bresp <= `NVP_RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `NVP_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= `NVP_RESP_OKAY;
      case (araddr)
        `NVP_OFF_STATUS: rdata <= {29'h00000000, ser_active, busy, prog_en};
        `NVP_OFF_CTRL:   rdata <= {31'h00000000, par_mode};
        `NVP_OFF_CAL:    rdata <= {24'h000000, cal};
        `NVP_OFF_FUSE:   rdata <= {8'h00, lock, fuse_hi, fuse_lo};
        default: begin
          rdata <= 32'h00000000;
          rresp <= `NVP_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // nvp_top

// ---- include/nvp_regs.vh ----
// constants for the nonvolatile programming ports
`ifndef NVP_REGS_VH
`define NVP_REGS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define NVP_CLK_MHZ        125
`define NVP_T_WD_SHORT_US  4500
`define NVP_T_WD_LONG_US   9000
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define NVP_OFF_STATUS     8'h00
`define NVP_OFF_CTRL       8'h04
`define NVP_OFF_CAL        8'h08
`define NVP_OFF_FUSE       8'h0C
`define NVP_ST_PROG        0
`define NVP_ST_BUSY        1
`define NVP_ST_SER         2
`define NVP_CTRL_PAR       0
`define NVP_CAL_RST        8'h80
`define NVP_FUSE_LO_RST    8'hFF
`define NVP_FUSE_HI_RST    8'hFF
`define NVP_LOCK_RST       8'hFF
`define NVP_RESP_OKAY      2'b00
`define NVP_RESP_SLVERR    2'b10
// ----------------------------------------
// parallel commands and load kinds
// ----------------------------------------
`define NVP_PC_FUSE_WR     8'h40
`define NVP_PC_LOCK_WR     8'h20
`define NVP_PC_FL_RD       8'h04
`define NVP_PC_SIG_RD      8'h08
`define NVP_PC_ERASE       8'h80
`define NVP_LK_CMD         2'b10
`define NVP_LK_DATA        2'b01
`define NVP_LK_ADDR        2'b00
// ----------------------------------------
// serial instructions
// ----------------------------------------
`define NVP_SI_PRE         8'hAC
`define NVP_SI_EN          8'h53
`define NVP_SI_ERASE       8'h80
`define NVP_SI_POLL        8'hF0
`define NVP_SI_LDL         8'h40
`define NVP_SI_LDH         8'h48
`define NVP_SI_WRPG        8'h4C
`define NVP_SI_RDL         8'h20
`define NVP_SI_RDH         8'h28
`define NVP_SI_RDEE        8'hA0
`define NVP_SI_WREE        8'hC0
`define NVP_SI_RDLK        8'h58
`define NVP_SI_RDFUS       8'h50
`define NVP_SI_RDSIG       8'h30
`define NVP_SI_RDCAL       8'h38
`define NVP_SI_WRLK        8'hE0
`define NVP_SI_WRFUS       8'hA0
`define NVP_SI_WRFUSH      8'hA8
`define NVP_SI_HI          8'h08
// ----------------------------------------
// memory sizes
// ----------------------------------------
`define NVP_FLASH_LAST     13'h1FFF
`define NVP_EE_LAST        13'h01FF
`define NVP_PAGE_LAST      13'h003F
`endif
